// >>> bro_defs.svh
`ifndef BRO_DEFS_SVH
`define BRO_DEFS_SVH

// timing
`define BRO_CLK_NS        100
`define BRO_TICK_NS       1000000
`define BRO_PRE_W         14

// widths
`define BRO_DLY_W         16
`define BRO_CFG_W         16
`define BRO_WARN_N        4
`define BRO_IRQ_N         4
`define BRO_ADR_W         8

// register offsets
`define BRO_OFS_CTRL      8'h00
`define BRO_OFS_MULTI     8'h04
`define BRO_OFS_REL_DLY   8'h08
`define BRO_OFS_APP_DLY   8'h0c
`define BRO_OFS_STATUS    8'h10
`define BRO_OFS_IRQ_STAT  8'h14
`define BRO_OFS_IRQ_CLR   8'h18
`define BRO_OFS_IRQ_EN    8'h1c

// control fields
`define BRO_CTRL_EN       0
`define BRO_CTRL_BGP      1
`define BRO_CTRL_RGP      2
`define BRO_CTRL_BSEL_LO  4
`define BRO_CTRL_BSEL_HI  5

// status fields
`define BRO_STS_EN        0
`define BRO_STS_HOLD      1
`define BRO_STS_RDY       2
`define BRO_STS_WARN      3
`define BRO_STS_WRAW_LO   4
`define BRO_STS_WRAW_HI   7
`define BRO_STS_BUSY      8

// interrupt bits
`define BRO_IRQ_WARN      0
`define BRO_IRQ_APPLIED   1
`define BRO_IRQ_RELEASED  2
`define BRO_IRQ_RDYCHG    3

// selector codes
`define BRO_SEL_HOLD_CLOSED  2'h1
`define BRO_SEL_HOLD_OPEN    2'h2
`define BRO_RSEL_NRDY_CLOSED 4'h1
`define BRO_RSEL_RDY_CLOSED  4'h2
`define BRO_RDY_DIG_LO    8
`define BRO_RDY_DIG_HI    11

// reset values
`define BRO_BSEL_RST      2'h3
`define BRO_CFG_RST       16'h0300
`define BRO_DLY_RST       16'h0000

`endif

// >>> bro_pkg.sv
`include "bro_defs.svh"

package bro_pkg;

	typedef enum logic [1:0] {
		BRO_ST_HOLD     = 2'b00,
		BRO_ST_REL_WAIT = 2'b01,
		BRO_ST_RELEASED = 2'b10,
		BRO_ST_APP_WAIT = 2'b11
	} bro_brk_e;

	typedef struct packed {
		logic [`BRO_DLY_W-1:0] cnt;
	} bro_cnt_s;

	typedef struct packed {
		logic [`BRO_WARN_N-1:0] warn_m;
		logic [`BRO_WARN_N-1:0] warn_s;
		logic                   pwr_m;
		logic                   pwr_s;
		logic                   en_req;
		logic                   brk_gp;
		logic                   rdy_gp;
		logic [1:0]             bsel;
		logic [`BRO_CFG_W-1:0]  cfg;
		logic [`BRO_DLY_W-1:0]  rel_dly;
		logic [`BRO_DLY_W-1:0]  app_dly;
		bro_brk_e               st;
		logic [`BRO_PRE_W-1:0]  pre;
		logic                   ready;
		logic                   warn_q;
		logic [`BRO_IRQ_N-1:0]  irq_stat;
		logic [`BRO_IRQ_N-1:0]  irq_en;
		logic                   ack;
		logic [31:0]            dat;
		logic                   brake_out;
		logic                   ready_out;
		logic                   irq;
	} bro_top_s;

endpackage

// >>> bro_delay_cnt.sv
`timescale 1ns/1ns
`default_nettype none
`include "bro_defs.svh"

module bro_delay_cnt
	import bro_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	// control
	input  wire logic                  load,
	input  wire logic [`BRO_DLY_W-1:0] load_val,
	input  wire logic                  tick,
	// result
	output logic                       zero
);

	bro_cnt_s s_ff;
	bro_cnt_s nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (load) begin
			nxt_s.cnt = load_val;
		end else if (tick && s_ff.cnt != '0) begin
			nxt_s.cnt = s_ff.cnt - `BRO_DLY_W'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	// stale on the load cycle itself; the caller waits one cycle
	assign zero = (s_ff.cnt == '0);

endmodule

`default_nettype wire

// >>> bro_top.sv
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "bro_defs.svh"

module bro_top
	import bro_pkg::*;
#(
	parameter int unsigned TICK_CYC = `BRO_TICK_NS / `BRO_CLK_NS
) (
	// clock, reset, enable
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	// wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [`BRO_ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic [31:0]                 wb_dat_o,
	output logic                        wb_ack_o,
	// drive condition pins
	input  wire logic [`BRO_WARN_N-1:0] warn_in,
	input  wire logic                   pwr_ok_in,
	// discrete outputs
	output logic                        brake_out,
	output logic                        ready_out,
	output logic                        irq
);

	////////////////////////////////////////////////////////////////////////////////
	// state and helpers

	bro_top_s s_ff;
	bro_top_s nxt_s;

	logic                  warn_any;
	logic                  en_eff;
	logic                  holding;
	logic                  ready_now;
	logic                  req;
	logic                  cnt_load;
	logic [`BRO_DLY_W-1:0] cnt_val;
	logic                  tick;
	logic                  cnt_zero;
	logic [3:0]            rsel;
	logic [`BRO_IRQ_N-1:0] irq_set;
	logic [`BRO_IRQ_N-1:0] irq_clr;

	function automatic logic [15:0] wr16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = d[7:0];
		end
		if (sel[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	bro_delay_cnt u_dly (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.ce       (ce),
		.load     (cnt_load),
		.load_val (cnt_val),
		.tick     (tick),
		.zero     (cnt_zero)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		nxt_s     = s_ff;
		cnt_load  = 1'b0;
		cnt_val   = s_ff.rel_dly;
		irq_set   = '0;
		irq_clr   = '0;
		req       = wb_cyc_i && wb_stb_i && !s_ff.ack;

		// two-stage pin synchronisers
		nxt_s.warn_m = warn_in;
		nxt_s.warn_s = s_ff.warn_m;
		nxt_s.pwr_m  = pwr_ok_in;
		nxt_s.pwr_s  = s_ff.pwr_m;

		warn_any  = |s_ff.warn_s;
		ready_now = s_ff.pwr_s && !warn_any;
		en_eff    = s_ff.en_req && ready_now;
		holding   = (s_ff.st == BRO_ST_HOLD) || (s_ff.st == BRO_ST_REL_WAIT);
		rsel      = s_ff.cfg[`BRO_RDY_DIG_HI:`BRO_RDY_DIG_LO];

		// bus write; a warning below still wins over a software enable
		nxt_s.ack = req;
		nxt_s.dat = '0;
		if (req && wb_we_i) begin
			if (wb_adr_i == `BRO_OFS_CTRL) begin
				if (wb_sel_i[0]) begin
					nxt_s.en_req = wb_dat_i[`BRO_CTRL_EN];
					nxt_s.brk_gp = wb_dat_i[`BRO_CTRL_BGP];
					nxt_s.rdy_gp = wb_dat_i[`BRO_CTRL_RGP];
					nxt_s.bsel   = wb_dat_i[`BRO_CTRL_BSEL_HI:`BRO_CTRL_BSEL_LO];
				end
			end else if (wb_adr_i == `BRO_OFS_MULTI) begin
				nxt_s.cfg = wr16(s_ff.cfg, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `BRO_OFS_REL_DLY) begin
				nxt_s.rel_dly = wr16(s_ff.rel_dly, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `BRO_OFS_APP_DLY) begin
				nxt_s.app_dly = wr16(s_ff.app_dly, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `BRO_OFS_IRQ_CLR) begin
				if (wb_sel_i[0]) begin
					irq_clr = wb_dat_i[`BRO_IRQ_N-1:0];
				end
			end else if (wb_adr_i == `BRO_OFS_IRQ_EN) begin
				if (wb_sel_i[0]) begin
					nxt_s.irq_en = wb_dat_i[`BRO_IRQ_N-1:0];
				end
			end
		end

		// bus read; unmapped offsets answer zero
		if (req && !wb_we_i) begin
			if (wb_adr_i == `BRO_OFS_CTRL) begin
				nxt_s.dat[`BRO_CTRL_EN]                        = s_ff.en_req;
				nxt_s.dat[`BRO_CTRL_BGP]                       = s_ff.brk_gp;
				nxt_s.dat[`BRO_CTRL_RGP]                       = s_ff.rdy_gp;
				nxt_s.dat[`BRO_CTRL_BSEL_HI:`BRO_CTRL_BSEL_LO] = s_ff.bsel;
			end else if (wb_adr_i == `BRO_OFS_MULTI) begin
				nxt_s.dat[`BRO_CFG_W-1:0] = s_ff.cfg;
			end else if (wb_adr_i == `BRO_OFS_REL_DLY) begin
				nxt_s.dat[`BRO_DLY_W-1:0] = s_ff.rel_dly;
			end else if (wb_adr_i == `BRO_OFS_APP_DLY) begin
				nxt_s.dat[`BRO_DLY_W-1:0] = s_ff.app_dly;
			end else if (wb_adr_i == `BRO_OFS_STATUS) begin
				nxt_s.dat[`BRO_STS_EN]                       = en_eff;
				nxt_s.dat[`BRO_STS_HOLD]                     = holding;
				nxt_s.dat[`BRO_STS_RDY]                      = s_ff.ready;
				nxt_s.dat[`BRO_STS_WARN]                     = warn_any;
				nxt_s.dat[`BRO_STS_WRAW_HI:`BRO_STS_WRAW_LO] = s_ff.warn_s;
				nxt_s.dat[`BRO_STS_BUSY]                     = !cnt_zero;
			end else if (wb_adr_i == `BRO_OFS_IRQ_STAT) begin
				nxt_s.dat[`BRO_IRQ_N-1:0] = s_ff.irq_stat;
			end else if (wb_adr_i == `BRO_OFS_IRQ_EN) begin
				nxt_s.dat[`BRO_IRQ_N-1:0] = s_ff.irq_en;
			end
		end

		// a fault drops the enable request; software must enable again
		if (warn_any) begin
			nxt_s.en_req = 1'b0;
		end

		// brake sequencer
		case (s_ff.st)
			BRO_ST_HOLD: begin
				if (en_eff) begin
					cnt_load = 1'b1;
					cnt_val  = s_ff.rel_dly;
					nxt_s.st = BRO_ST_REL_WAIT;
				end
			end
			BRO_ST_REL_WAIT: begin
				if (!en_eff) begin
					nxt_s.st = BRO_ST_HOLD;
				end else if (cnt_zero) begin
					nxt_s.st                    = BRO_ST_RELEASED;
					irq_set[`BRO_IRQ_RELEASED] = 1'b1;
				end
			end
			BRO_ST_RELEASED: begin
				if (!en_eff) begin
					cnt_load = 1'b1;
					cnt_val  = s_ff.app_dly;
					nxt_s.st = BRO_ST_APP_WAIT;
				end
			end
			BRO_ST_APP_WAIT: begin
				if (en_eff) begin
					nxt_s.st = BRO_ST_RELEASED;
				end else if (cnt_zero) begin
					nxt_s.st                   = BRO_ST_HOLD;
					irq_set[`BRO_IRQ_APPLIED] = 1'b1;
				end
			end
			default: begin
				nxt_s.st = BRO_ST_HOLD;
			end
		endcase

		// delay unit prescaler, restarted on each load so delays are exact
		tick = (s_ff.pre == `BRO_PRE_W'(TICK_CYC - 1)) && !cnt_load;
		if (cnt_load || tick) begin
			nxt_s.pre = '0;
		end else begin
			nxt_s.pre = s_ff.pre + `BRO_PRE_W'(1);
		end

		// events
		nxt_s.ready  = ready_now;
		nxt_s.warn_q = warn_any;
		irq_set[`BRO_IRQ_WARN]   = warn_any && !s_ff.warn_q;
		irq_set[`BRO_IRQ_RDYCHG] = ready_now != s_ff.ready;
		// set wins over a clear in the same cycle
		nxt_s.irq_stat = (s_ff.irq_stat & ~irq_clr) | irq_set;
		nxt_s.irq      = |(s_ff.irq_stat & s_ff.irq_en);

		// brake contact
		if (s_ff.bsel == `BRO_SEL_HOLD_CLOSED) begin
			nxt_s.brake_out = holding;
		end else if (s_ff.bsel == `BRO_SEL_HOLD_OPEN) begin
			nxt_s.brake_out = !holding;
		end else begin
			nxt_s.brake_out = s_ff.brk_gp;
		end

		// ready contact
		if (rsel == `BRO_RSEL_NRDY_CLOSED) begin
			nxt_s.ready_out = !s_ff.ready;
		end else if (rsel == `BRO_RSEL_RDY_CLOSED) begin
			nxt_s.ready_out = s_ff.ready;
		end else begin
			nxt_s.ready_out = s_ff.rdy_gp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_ff         <= '0;
			s_ff.bsel    <= `BRO_BSEL_RST;
			s_ff.cfg     <= `BRO_CFG_RST;
			s_ff.rel_dly <= `BRO_DLY_RST;
			s_ff.app_dly <= `BRO_DLY_RST;
			s_ff.st      <= BRO_ST_HOLD;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign wb_dat_o  = s_ff.dat;
	assign wb_ack_o  = s_ff.ack;
	assign brake_out = s_ff.brake_out;
	assign ready_out = s_ff.ready_out;
	assign irq       = s_ff.irq;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	chk_brake_polarity: assert property (
		(ce && s_ff.bsel == `BRO_SEL_HOLD_OPEN) |=> (brake_out == !$past(holding)))
		else $error("brake contact does not follow inverted hold state");

	chk_brake_gp_pin: assert property (
		(ce && s_ff.bsel == `BRO_BSEL_RST) |=> (brake_out == $past(s_ff.brk_gp)))
		else $error("brake pin in default mode does not follow plain level");

	chk_release_needs_en: assert property (
		$rose(s_ff.st == BRO_ST_RELEASED) |-> $past(en_eff))
		else $error("brake released while motor not enabled");

	chk_release_seq: assert property (
		(ce && s_ff.st == BRO_ST_HOLD && en_eff) |=> (s_ff.st == BRO_ST_REL_WAIT && holding))
		else $error("release did not start a delay with brake still held");

	chk_ready_warn: assert property (
		(ce && warn_any) |=> !s_ff.ready ##1 (!$past(ce)
			|| (ready_out == (rsel == `BRO_RSEL_NRDY_CLOSED))
			|| (rsel != `BRO_RSEL_NRDY_CLOSED && rsel != `BRO_RSEL_RDY_CLOSED)))
		else $error("ready reported while a warning is active");

	chk_ready_pol: assert property (
		(ce && rsel == `BRO_RSEL_RDY_CLOSED) |=> (ready_out == $past(s_ff.ready)))
		else $error("ready contact not closed with ready");

	chk_ready_gp_pin: assert property (
		(ce && rsel == 4'h3) |=> (ready_out == $past(s_ff.rdy_gp)))
		else $error("ready pin in default mode does not follow plain level");

	chk_ready_digit: assert property (
		(ce && s_ff.cfg[`BRO_RDY_DIG_HI:`BRO_RDY_DIG_LO] == `BRO_RSEL_NRDY_CLOSED)
			|=> (ready_out == !$past(s_ff.ready)))
		else $error("ready selector not taken from third digit");

	chk_warn_disable: assert property (
		(ce && warn_any) |-> (!en_eff ##1 !s_ff.en_req))
		else $error("warning did not disable the motor at once");

	chk_apply_zero: assert property (
		(ce && s_ff.st == BRO_ST_APP_WAIT && !en_eff && cnt_zero) |=> (s_ff.st == BRO_ST_HOLD))
		else $error("brake not applied when delay count reached zero");

	// every antecedent but chk_release_needs_en and chk_ce_freeze carries ce: a frozen cycle moves no state
	chk_ce_freeze: assert property (
		!ce |=> $stable(s_ff))
		else $error("state moved while the clock enable was low");

	chk_brake_hold_closed: assert property (
		(ce && s_ff.bsel == `BRO_SEL_HOLD_CLOSED) |=> (brake_out == $past(holding)))
		else $error("brake contact does not follow hold state");

	chk_hold_when_off: assert property (
		(ce && s_ff.st == BRO_ST_HOLD && !en_eff) |=> (s_ff.st == BRO_ST_HOLD))
		else $error("brake left hold while motor disabled");

	chk_release_abort: assert property (
		(ce && s_ff.st == BRO_ST_REL_WAIT && !en_eff) |=> (s_ff.st == BRO_ST_HOLD))
		else $error("release delay not abandoned when enable dropped");

	chk_apply_seq: assert property (
		(ce && s_ff.st == BRO_ST_RELEASED && !en_eff)
			|=> (s_ff.st == BRO_ST_APP_WAIT && !holding))
		else $error("apply did not start a delay with brake still released");

	chk_ready_flag: assert property (
		(ce && s_ff.pwr_s && !warn_any) |=> s_ff.ready)
		else $error("ready flag not set while powered without warning");

	chk_release_zero: assert property (
		(ce && s_ff.st == BRO_ST_REL_WAIT && en_eff && cnt_zero)
			|=> (s_ff.st == BRO_ST_RELEASED))
		else $error("brake not released when delay count reached zero");

	chk_wb_ack: assert property (
		(ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("wishbone request not answered in one cycle");

endmodule

`default_nettype wire

// >>> bro_far_side.sv
`timescale 1ns/1ns
`default_nettype none

module bro_far_side (
	// contacts from the drive
	input  wire logic brake_out,
	input  wire logic ready_out,
	// wiring polarity chosen by the installer
	input  wire logic hold_closed,
	input  wire logic rdy_closed,
	// what the brake coil and the host see
	output logic      shaft_held,
	output logic      host_ready
);
	// a closed contact means holding only when wired that way
	assign shaft_held = brake_out ~^ hold_closed;
	assign host_ready = ready_out ~^ rdy_closed;
endmodule

`default_nettype wire

// >>> test_brake_and_ready_outputs.sv
`timescale 1ns/1ns
`default_nettype none
`include "bro_defs.svh"

module test_brake_and_ready_outputs;
	logic        clk_sys, rst_n, cyc, stb, we, ack, irq;
	logic        brake_out, ready_out, pwr, hold_pol, rdy_pol, ce;
	logic        shaft_held, host_ready;
	logic [3:0]  warn, sel;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q;
	logic [15:0] rnd;
	int          fails, n_tests, rd, ad, b, i;

	bro_top #(.TICK_CYC(4)) bro_top_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.warn_in(warn), .pwr_ok_in(pwr),
		.brake_out(brake_out), .ready_out(ready_out), .irq(irq)
	);

	bro_far_side bro_far_side_inst (
		.brake_out(brake_out), .ready_out(ready_out),
		.hold_closed(hold_pol), .rdy_closed(rdy_pol),
		.shaft_held(shaft_held), .host_ready(host_ready)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one classic cycle; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			fails++;
			tally_and_finish();
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// bounded wait for the shaft state, flagging too early or too late
	task automatic wait_lvl(input logic e, input int lo, input int hi);
		int n;
		n = 0;
		while (shaft_held !== e && n < hi) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n >= lo && n < hi, 1);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		{rst_n, cyc, stb, we, pwr, hold_pol, rdy_pol} = '0;
		{warn, sel, adr, wdat} = '0;
		ce = 1'b1;
		fails = 0;
		n_tests = 0;
		rnd = 16'hd667;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(0, `BRO_OFS_CTRL, 0);
		chk(q, 32'h30);
		bus(0, `BRO_OFS_MULTI, 0);
		chk(q, 32'h300);
		bus(0, 8'h20, 0);
		chk(q, 0);
		bus(0, `BRO_OFS_IRQ_CLR, 0);
		chk(q, 0);
		// default selectors leave both pins as plain outputs
		for (i = 0; i < 4; i++) begin
			bus(1, `BRO_OFS_CTRL, 32'h30 | (i << 1));
			cycles(3);
			chk(brake_out, i[0]);
			chk(ready_out, i[1]);
		end
		pwr <= 1'b1;
		for (i = 1; i < 3; i++) begin
			rdy_pol = (i == 2);
			bus(1, `BRO_OFS_MULTI, i << 8);
			cycles(6);
			chk(host_ready, 1);
			rnd = lfsr(rnd);
			warn <= rnd[3:0] | 4'h1;
			cycles(6);
			chk(host_ready, 0);
			bus(0, `BRO_OFS_STATUS, 0);
			chk(q[7:3], {warn, 1'b1});
			warn <= 4'h0;
			cycles(6);
			chk(host_ready, 1);
		end
		// a low enable freezes synchronisers and contacts alike
		ce   <= 1'b0;
		warn <= 4'h4;
		cycles(6);
		chk(host_ready, 1);
		ce <= 1'b1;
		cycles(6);
		chk(host_ready, 0);
		warn <= 4'h0;
		cycles(6);
		chk(host_ready, 1);
		bus(1, `BRO_OFS_IRQ_EN, 32'h5);
		bus(1, `BRO_OFS_IRQ_CLR, 32'hf);
		for (b = 1; b < 3; b++) begin
			hold_pol = (b == 1);
			rnd = lfsr(rnd);
			rd = 1 + rnd[7:0] % 3;
			ad = 1 + rnd[15:8] % 3;
			bus(1, `BRO_OFS_REL_DLY, rd);
			bus(1, `BRO_OFS_APP_DLY, ad);
			bus(1, `BRO_OFS_CTRL, b << 4);
			cycles(3);
			chk(shaft_held, 1);
			// enable withdrawn mid-delay must never release
			bus(1, `BRO_OFS_CTRL, (b << 4) | 1);
			bus(1, `BRO_OFS_CTRL, b << 4);
			cycles(rd * 4 + 8);
			chk(shaft_held, 1);
			bus(1, `BRO_OFS_CTRL, (b << 4) | 1);
			wait_lvl(0, rd * 4 - 1, rd * 4 + 6);
			cycles(2);
			chk(irq, 1);
			bus(0, `BRO_OFS_IRQ_STAT, 0);
			chk(q[2], 1);
			bus(1, `BRO_OFS_IRQ_CLR, 32'h4);
			cycles(2);
			chk(irq, 0);
			if (b == 1)
				warn <= rnd[3:0] | 4'h2;
			else
				pwr <= 1'b0;
			wait_lvl(1, ad * 4, ad * 4 + 10);
			chk(host_ready, 0);
			bus(0, `BRO_OFS_CTRL, 0);
			if (b == 1)
				chk(q[0], 0);
			if (b == 1)
				chk(irq, 1);
			bus(1, `BRO_OFS_IRQ_EN, 0);
			cycles(2);
			chk(irq, 0);
			bus(1, `BRO_OFS_CTRL, b << 4);
			bus(1, `BRO_OFS_IRQ_CLR, 32'hf);
			bus(1, `BRO_OFS_IRQ_EN, 32'h5);
			warn <= 4'h0;
			pwr <= 1'b1;
			cycles(6);
		end
		tally_and_finish();
	end
endmodule

`default_nettype wire
